// File: hw/sapf_ctrl.sv
// Purpose: register file and control of a 10-bit SAR converter with
//          threshold comparison
// Assumes: one system clock, synchronous reset, comparator output is
//          asynchronous to the clock
// Notes:   reads return data one clock after the read strobe
`default_nettype none

// How it works
// - with comparison on, result upper eight bits are compared to threshold
// - threshold register reads zero after reset
// - sample selected input for a set time, then hold until done
// - first step tries bit 9 at half-scale tap
// - later steps try next bit, tap from decided bits, keep when ge
// - after bit 0 the value goes to the result register
// - conversions repeat back to back while run bit 7 is set
// - any write to a control register aborts and restarts if running
// - result is rounded ratio times 1024, stored left aligned by 64
// - single selected input out of eight by the channel field
// - compare mode bit 7 picks plain conversion or threshold detect
// - comparison off: every result stored and done pulse raised
// - clearing run bit stops conversion at once, result undefined
// - polarity 0: done pulse only when upper bits ge threshold
// - polarity 1: done pulse only when upper bits below threshold
// - each completion overwrites the result, read or not
// - result register is not cleared by reset
module sapf_ctrl (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  output logic      [2:0]  channel_bits,
  output logic             sample_hold_sample,
  output logic      [9:0]  ladder_tap,
  output logic             compare_req,
  input  wire logic        comparator_high,
  output logic             reference_gen_enable,
  output logic             conversion_active,
  output logic             conversion_done_irq
);

  // software-visible state
  logic [7:0] converter_mode_reg;
  logic [7:0] channel_select_reg;
  logic [7:0] compare_mode_reg;
  logic [7:0] compare_threshold_reg;
  logic [9:0] conversion_result_reg;
  logic [7:0] rdata_reg;
  logic       irq_reg;

  // comparator synchroniser
  logic       cmp_meta_reg;
  logic       cmp_sync_reg;

  // control terms
  logic       ctl_write;
  logic       done_ok;
  logic       conversion_run;
  logic       compare_enable;
  logic       compare_polarity;
  logic [2:0] conversion_time_sel;
  logic [7:0] rdata_next;

  sapf_sar_if sar ();

  // a write to any of the four control registers counts here
  function automatic logic is_ctl_addr(input logic [15:0] a);
    is_ctl_addr = (a == sapf_pkg::ADDR_MODE)    ||
                  (a == sapf_pkg::ADDR_CHANNEL) ||
                  (a == sapf_pkg::ADDR_CMP_MODE) ||
                  (a == sapf_pkg::ADDR_THRESHOLD);
  endfunction

  // whole conversion time in clocks for a time select code;
  // unlisted codes are not allowed, so fall back to the slowest
  function automatic logic [8:0] conv_cycles(input logic [2:0] sel);
    case (sel)
      sapf_pkg::TSEL_192: conv_cycles = sapf_pkg::CONV_CYC_192;
      sapf_pkg::TSEL_144: conv_cycles = sapf_pkg::CONV_CYC_144;
      sapf_pkg::TSEL_120: conv_cycles = sapf_pkg::CONV_CYC_120;
      sapf_pkg::TSEL_96:  conv_cycles = sapf_pkg::CONV_CYC_96;
      default:            conv_cycles = sapf_pkg::CONV_CYC_192;
    endcase
  endfunction

  // threshold test on the upper eight result bits
  function automatic logic cmp_pass(
    input logic       en,
    input logic       pol,
    input logic [7:0] upper,
    input logic [7:0] thr
  );
    if (!en) begin
      cmp_pass = 1'b1;
    end else if (!pol) begin
      cmp_pass = (upper >= thr);
    end else begin
      cmp_pass = (upper < thr);
    end
  endfunction

  // field extraction
  assign conversion_run      = converter_mode_reg[sapf_pkg::MODE_RUN_BIT];
  assign conversion_time_sel =
    converter_mode_reg[sapf_pkg::MODE_TSEL_MSB:sapf_pkg::MODE_TSEL_LSB];
  assign compare_enable      = compare_mode_reg[sapf_pkg::CMP_EN_BIT];
  assign compare_polarity    = compare_mode_reg[sapf_pkg::CMP_POL_BIT];
  assign ctl_write           = bus_wr && is_ctl_addr(bus_addr);

  // mode register: run, time select, reference enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      converter_mode_reg <= sapf_pkg::MODE_RST;
    end else if (bus_wr && bus_addr == sapf_pkg::ADDR_MODE) begin
      converter_mode_reg <= bus_wdata;
    end
  end

  // channel register: only the three select bits are stored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      channel_select_reg <= sapf_pkg::CHAN_RST;
    end else if (bus_wr && bus_addr == sapf_pkg::ADDR_CHANNEL) begin
      channel_select_reg <= {5'h00, bus_wdata[sapf_pkg::CHAN_W-1:0]};
    end
  end

  // comparison mode register: enable and polarity only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      compare_mode_reg <= sapf_pkg::CMP_MODE_RST;
    end else if (bus_wr && bus_addr == sapf_pkg::ADDR_CMP_MODE) begin
      compare_mode_reg <= {bus_wdata[sapf_pkg::CMP_EN_BIT],
                           bus_wdata[sapf_pkg::CMP_POL_BIT], 6'h00};
    end
  end

  // threshold register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      compare_threshold_reg <= sapf_pkg::THRESHOLD_RST;
    end else if (bus_wr && bus_addr == sapf_pkg::ADDR_THRESHOLD) begin
      compare_threshold_reg <= bus_wdata;
    end
  end

  // comparator output comes from the analog side: two flops first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmp_meta_reg <= 1'b0;
      cmp_sync_reg <= 1'b0;
    end else begin
      cmp_meta_reg <= comparator_high;
      cmp_sync_reg <= cmp_meta_reg;
    end
  end

  // sequencer requests; a control write in the same cycle as the
  // last decision wins, so that result is dropped with no pulse
  assign sar.abort         = ctl_write;
  assign sar.start         = conversion_run && !sar.busy &&
                             !ctl_write;
  assign sar.sample_cycles = conv_cycles(conversion_time_sel) -
                             sapf_pkg::SAR_CYC;
  assign sar.cmp_high      = cmp_sync_reg;
  assign done_ok           = sar.done && !ctl_write;

  sapf_sar_engine u_engine (
    .clk   (clk),
    .rst_n (rst_n),
    .sar   (sar)
  );

  // result is kept without reset and overwritten at every end
  always_ff @(posedge clk) begin
    if (done_ok) begin
      conversion_result_reg <= sar.result;
    end
  end

  // done pulse registered alongside the result update
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= done_ok &&
                 cmp_pass(compare_enable, compare_polarity,
                          sar.result[sapf_pkg::RES_W-1:
                                     sapf_pkg::RES_W-sapf_pkg::THR_W],
                          compare_threshold_reg);
    end
  end

  // read mux; the result reads left aligned in two bytes
  always_comb begin
    rdata_next = 8'h00;
    case (bus_addr)
      sapf_pkg::ADDR_RESULT_LO:
        rdata_next = {conversion_result_reg[1:0], 6'h00};
      sapf_pkg::ADDR_RESULT_HI:
        rdata_next = conversion_result_reg[9:2];
      sapf_pkg::ADDR_MODE:      rdata_next = converter_mode_reg;
      sapf_pkg::ADDR_CHANNEL:   rdata_next = channel_select_reg;
      sapf_pkg::ADDR_CMP_MODE:  rdata_next = compare_mode_reg;
      sapf_pkg::ADDR_THRESHOLD: rdata_next = compare_threshold_reg;
      default:                  rdata_next = 8'h00;
    endcase
  end

  // read data held until the next read strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (bus_rd) begin
      rdata_reg <= rdata_next;
    end
  end

  // analog-side outputs, then status and read data
  assign channel_bits         =
    channel_select_reg[sapf_pkg::CHAN_W-1:0];
  assign sample_hold_sample   = sar.sample_on;
  assign ladder_tap           = sar.tap;
  assign compare_req          = sar.cmp_req;
  assign reference_gen_enable = converter_mode_reg[sapf_pkg::MODE_REF_BIT];
  assign conversion_active    = sar.busy;
  assign conversion_done_irq  = irq_reg;
  assign bus_rdata            = rdata_reg;

endmodule

`default_nettype wire

// File: hw/sapf_pkg.sv
// Purpose: shared constants and types of the converter control block
// Assumes: 10 MHz system clock, 16-bit register address, 8-bit data
// Notes:   the conversion clock is the system clock itself
`default_nettype none

package sapf_pkg;

  // clock rate and reference settling time (software waits for it)
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned REF_SETTLE_US   = 14;
  localparam int unsigned REF_SETTLE_CYC  =
    (REF_SETTLE_US * (CLK_HZ / 1_000_000));

  // register addresses
  localparam logic [15:0] ADDR_RESULT_LO  = 16'hff08;
  localparam logic [15:0] ADDR_RESULT_HI  = 16'hff09;
  localparam logic [15:0] ADDR_MODE       = 16'hff28;
  localparam logic [15:0] ADDR_CHANNEL    = 16'hff29;
  localparam logic [15:0] ADDR_CMP_MODE   = 16'hff2a;
  localparam logic [15:0] ADDR_THRESHOLD  = 16'hff2b;

  // field positions
  localparam int unsigned MODE_RUN_BIT    = 7;
  localparam int unsigned MODE_TSEL_LSB   = 3;
  localparam int unsigned MODE_TSEL_MSB   = 5;
  localparam int unsigned MODE_REF_BIT    = 0;
  localparam int unsigned CMP_EN_BIT      = 7;
  localparam int unsigned CMP_POL_BIT     = 6;
  localparam int unsigned CHAN_W          = 3;

  // reset values
  localparam logic [7:0]  MODE_RST        = 8'h00;
  localparam logic [7:0]  CHAN_RST        = 8'h00;
  localparam logic [7:0]  CMP_MODE_RST    = 8'h00;
  localparam logic [7:0]  THRESHOLD_RST   = 8'h00;

  // converter geometry
  localparam int unsigned RES_W           = 10;
  localparam int unsigned THR_W           = 8;
  localparam logic [3:0]  SAR_MSB         = 4'h9;
  localparam logic [9:0]  SAR_HALF        = 10'h200;

  // cycles per SAR step (tap settles, request, then capture) and for all ten steps
  localparam logic [8:0]  STEP_CYC        = 9'h004;
  localparam logic [8:0]  SAR_CYC         = 9'h028;

  // whole conversion times in clocks, per time select code
  localparam logic [2:0]  TSEL_192        = 3'h2;
  localparam logic [2:0]  TSEL_144        = 3'h4;
  localparam logic [2:0]  TSEL_120        = 3'h5;
  localparam logic [2:0]  TSEL_96         = 3'h6;
  localparam logic [8:0]  CONV_CYC_192    = 9'h0c0;
  localparam logic [8:0]  CONV_CYC_144    = 9'h090;
  localparam logic [8:0]  CONV_CYC_120    = 9'h078;
  localparam logic [8:0]  CONV_CYC_96     = 9'h060;

  typedef enum logic [1:0] {
    SAPF_IDLE    = 2'b00,
    SAPF_SAMPLE  = 2'b01,
    SAPF_CONVERT = 2'b10
  } sapf_state_e;

endpackage

`default_nettype wire

// File: hw/sapf_sar_if.sv
// Purpose: link between register side and the SAR sequencer
// Assumes: both ends on the same clock
// Notes:   start and abort are single-cycle requests
`default_nettype none

interface sapf_sar_if;
  logic       start;
  logic       abort;
  logic [8:0] sample_cycles;
  logic       cmp_high;
  logic       busy;
  logic       done;
  logic [9:0] result;
  logic       sample_on;
  logic [9:0] tap;
  logic       cmp_req;

  modport ctrl (
    output start, abort, sample_cycles, cmp_high,
    input  busy, done, result, sample_on, tap, cmp_req
  );
  modport eng (
    input  start, abort, sample_cycles, cmp_high,
    output busy, done, result, sample_on, tap, cmp_req
  );
endinterface

`default_nettype wire

// File: hw/sapf_sar_engine.sv
// Purpose: sample, hold and bit-by-bit successive approximation
// Assumes: cmp_high is already synchronised, high when input >= tap
// Notes:   abort wins over every other event in the same cycle except the approximation register load
`default_nettype none

module sapf_sar_engine (
  input wire logic clk,
  input wire logic rst_n,
  sapf_sar_if.eng  sar
);

  sapf_pkg::sapf_state_e state_reg;
  logic [8:0]            cnt_reg;
  logic [3:0]            bit_reg;
  logic [9:0]            sar_reg;
  logic                  step_end;
  logic [9:0]            decided;
  logic [9:0]            bit_mask;

  assign step_end = (cnt_reg == sapf_pkg::STEP_CYC - 9'h001);
  assign bit_mask = 10'h001 << bit_reg;
  // the bit under test is kept only if the comparator says so
  assign decided  = sar.cmp_high ? sar_reg : (sar_reg & ~bit_mask);

  // sequencing: sample window, then ten steps of four clocks
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= sapf_pkg::SAPF_IDLE;
      cnt_reg   <= 9'h000;
      bit_reg   <= 4'h0;
    end else if (sar.abort) begin
      state_reg <= sapf_pkg::SAPF_IDLE;
      cnt_reg   <= 9'h000;
    end else begin
      case (state_reg)
        sapf_pkg::SAPF_IDLE: begin
          cnt_reg <= 9'h000;
          if (sar.start) begin
            state_reg <= sapf_pkg::SAPF_SAMPLE;
          end
        end
        sapf_pkg::SAPF_SAMPLE: begin
          if (cnt_reg == sar.sample_cycles - 9'h001) begin
            state_reg <= sapf_pkg::SAPF_CONVERT; // hold from here
            cnt_reg   <= 9'h000;
            bit_reg   <= sapf_pkg::SAR_MSB;
          end else begin
            cnt_reg <= cnt_reg + 9'h001;
          end
        end
        sapf_pkg::SAPF_CONVERT: begin
          if (step_end) begin
            cnt_reg <= 9'h000;
            if (bit_reg == 4'h0) begin
              state_reg <= sapf_pkg::SAPF_IDLE;
            end else begin
              bit_reg <= bit_reg - 4'h1;
            end
          end else begin
            cnt_reg <= cnt_reg + 9'h001;
          end
        end
        default: begin
          state_reg <= sapf_pkg::SAPF_IDLE;
        end
      endcase
    end
  end

  // approximation register: trial bit set, then kept or cleared
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sar_reg <= 10'h000;
    end else if (state_reg == sapf_pkg::SAPF_SAMPLE) begin
      sar_reg <= sapf_pkg::SAR_HALF; // half-scale tap first
    end else if (state_reg == sapf_pkg::SAPF_CONVERT && step_end) begin
      // next tap built from bits already decided
      sar_reg <= (bit_reg == 4'h0) ? decided : (decided | (bit_mask >> 1));
    end
  end

  assign sar.busy      = (state_reg != sapf_pkg::SAPF_IDLE);
  assign sar.sample_on = (state_reg == sapf_pkg::SAPF_SAMPLE);
  assign sar.tap       = sar_reg;
  // request one clock before the decision is taken
  assign sar.cmp_req   = (state_reg == sapf_pkg::SAPF_CONVERT) &&
                         (cnt_reg == sapf_pkg::STEP_CYC - 9'h002);
  assign sar.done      = (state_reg == sapf_pkg::SAPF_CONVERT) && step_end &&
                         (bit_reg == 4'h0) && !sar.abort;
  assign sar.result    = decided;

endmodule

`default_nettype wire

// File: dv/sapf_analog_model.sv
// Purpose: analog side: input mux, sample-and-hold, ladder, comparator
// Assumes: inputs are given in half steps of the reference (11 bits)
// Notes:   no reset; the hold node starts discharged
`default_nettype none

module sapf_analog_model (
  input  wire logic             clk,
  input  wire logic [7:0][10:0] ain,
  input  wire logic [2:0]       channel_bits,
  input  wire logic             sample_hold_sample,
  input  wire logic [9:0]       ladder_tap,
  output logic                  comparator_high
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] held = 11'h000;

  // track the selected input while sampling, freeze it in hold
  always_ff @(posedge clk) begin
    if (sample_hold_sample) begin
      held <= ain[channel_bits];
    end
  end

  // taps sit half a step low, so the code rounds to nearest
  always_comb begin
    comparator_high = ({1'b0, held} + 12'h001) >=
                      {1'b0, ladder_tap, 1'b0};
  end
endmodule

`default_nettype wire

// File: dv/sapf_ctrl_assertions.sv
// Purpose: port-level checks of the converter control block
// Assumes: a control write aborts on the very edge that takes it
// Notes:   bound into every sapf_ctrl instance
`default_nettype none

module sapf_ctrl_assertions (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [15:0] bus_addr,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [7:0]  bus_wdata,
  input wire logic [7:0]  bus_rdata,
  input wire logic [2:0]  channel_bits,
  input wire logic        sample_hold_sample,
  input wire logic [9:0]  ladder_tap,
  input wire logic        compare_req,
  input wire logic        comparator_high,
  input wire logic        reference_gen_enable,
  input wire logic        conversion_active,
  input wire logic        conversion_done_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // any write to the four control registers
  logic wr_ctl;
  logic wr_mode;
  assign wr_ctl  = bus_wr && bus_addr >= 16'hff28 && bus_addr <= 16'hff2b;
  assign wr_mode = bus_wr && bus_addr == 16'hff28;

  chk_irq_single: assert property (
    conversion_done_irq |=> !conversion_done_irq)
    else $error("done pulse longer than one clock");
  chk_irq_at_end: assert property (
    conversion_done_irq |-> !conversion_active && !sample_hold_sample)
    else $error("done pulse while still converting");
  chk_write_abort: assert property (
    wr_ctl |=> !conversion_active && !conversion_done_irq)
    else $error("control write did not abort");
  chk_run_stop: assert property (
    wr_mode && !bus_wdata[7] ##1 (!bus_wr)[*3]
    |-> !conversion_active && !sample_hold_sample && !compare_req)
    else $error("converter kept running after stop");
  chk_req_spacing: assert property (
    compare_req |=> (!compare_req)[*3])
    else $error("compare requests closer than a step");
  chk_tap_held: assert property (
    compare_req |-> $stable(ladder_tap) && !sample_hold_sample)
    else $error("tap moved or sampling during compare");
  chk_tap_first: assert property (
    $fell(sample_hold_sample) && conversion_active |-> ladder_tap == 10'h200)
    else $error("first trial is not half scale");
  chk_sample_first: assert property (
    $rose(conversion_active) |-> sample_hold_sample)
    else $error("conversion did not begin by sampling");
  chk_ref_follow: assert property (
    wr_mode |=> reference_gen_enable == $past(bus_wdata[0]))
    else $error("reference enable does not follow mode bit 0");
  chk_chan_follow: assert property (
    bus_wr && bus_addr == 16'hff29 |=> channel_bits == $past(bus_wdata[2:0]))
    else $error("channel select does not follow register");
endmodule

bind sapf_ctrl sapf_ctrl_assertions chk_u (.clk, .rst_n, .bus_addr, .bus_wr,
  .bus_rd, .bus_wdata, .bus_rdata, .channel_bits, .sample_hold_sample,
  .ladder_tap, .compare_req, .comparator_high, .reference_gen_enable,
  .conversion_active, .conversion_done_irq);

`default_nettype wire

// File: dv/sapf_ctrl_test.sv
// Purpose: register-level test of the converter control block
// Assumes: one access every two clocks, inputs driven at falling edge
// Notes:   latency counts run from the write cycle to the done pulse
`default_nettype none

module sapf_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk, rst_n, bus_wr, bus_rd, cmp_high, irq, active;
  logic             sh, req, ref_en;
  logic [15:0]      bus_addr, rd_val;
  logic [7:0]       bus_wdata, rdata;
  logic [2:0]       chan;
  logic [9:0]       tap;
  logic [7:0][10:0] ain;
  int               err_total, checked, n;
  logic [2:0]       tsel_tab [5] = '{3'h2, 3'h4, 3'h5, 3'h6, 3'h0};
  int               t_tab [5] = '{192, 144, 120, 96, 192};

  sapf_ctrl dut_u (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
    .bus_rdata(rdata), .channel_bits(chan), .sample_hold_sample(sh),
    .ladder_tap(tap), .compare_req(req), .comparator_high(cmp_high),
    .reference_gen_enable(ref_en), .conversion_active(active),
    .conversion_done_irq(irq));
  sapf_analog_model ana_u (.clk(clk), .ain(ain), .channel_bits(chan),
    .sample_hold_sample(sh), .ladder_tap(tap), .comparator_high(cmp_high));

  // free-running 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic print_verdict();
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // strobe for one edge, then one quiet cycle so strobes never abut
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge clk);
    bus_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [15:0] a);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge clk);
    bus_rd = 1'b0;
    rd_val = {8'h00, rdata};
    @(negedge clk);
  endtask

  // count falling edges until the done pulse; 0 means none came
  task automatic wait_irq(input int k0, output int k);
    k = k0;
    do begin
      @(negedge clk);
      k++;
    end while (irq !== 1'b1 && k < 600);
    if (irq !== 1'b1) k = 0;
  endtask

  task automatic chk_res(input int ch);
    logic [9:0] e;
    e = 10'((ain[ch] + 12'h001) >> 1);
    rd(16'hff09);
    check(rd_val, {8'h00, e[9:2]});
    rd(16'hff08);
    check(rd_val, {8'h00, e[1:0], 6'h00});
  endtask

  // hang guard, far beyond the expected 4500 or so clocks
  initial begin
    #5_000_000;
    err_total++;
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    err_total = 0;
    checked = 0;
    ain = {11'h7fd, 11'h001, 11'h400, 11'h3ff,
           11'h155, 11'h6aa, 11'h000, 11'h2c8};
    repeat (9) @(negedge clk);
    rst_n = 1'b1;
    // cleared control registers, last address is unmapped
    for (int a = 0; a < 5; a++) begin
      rd(16'hff28 + 16'(a));
      check(rd_val, 16'h0000);
    end
    wr(16'hff2b, 8'ha5);
    rd(16'hff2b);
    check(rd_val, 16'h00a5);
    wr(16'hff29, 8'hfb);
    rd(16'hff29);
    check(rd_val, 16'h0003);
    // reference on alone, then its settling time before the first run;
    // the settled reference makes the first result usable
    wr(16'hff28, 8'h01);
    check({15'h0000, ref_en}, 16'h0001);
    repeat (sapf_pkg::REF_SETTLE_CYC) @(negedge clk);
    // every time select, start latency, repeat period and code
    for (int i = 0; i < 5; i++) begin
      wr(16'hff29, 8'((i * 3) % 8));
      wr(16'hff28, {2'b10, tsel_tab[i], 3'b001});
      wait_irq(2, n);
      check(16'(n), 16'(t_tab[i] + 2));
      wait_irq(0, n);
      check(16'(n), 16'(t_tab[i] + 1));
      chk_res((i * 3) % 8);
    end
    // new input level replaces an unread result
    wait_irq(0, n);
    ain[4] = 11'h0ff;
    wait_irq(0, n);
    chk_res(4);
    // a threshold write mid-conversion restarts from the beginning
    repeat (60) @(negedge clk);
    wr(16'hff2b, 8'h00);
    wait_irq(2, n);
    check(16'(n), 16'h00c2);
    // clearing the run bit stops at once
    repeat (60) @(negedge clk);
    wr(16'hff28, 8'h01);
    wait_irq(2, n);
    check(16'(n), 16'h0000);
    check({15'h0000, active}, 16'h0000);
    // both polarities at the threshold boundary, code upper bits 59
    for (int i = 0; i < 4; i++) begin
      wr(16'hff29, 8'h00);
      wr(16'hff2a, {1'b1, i[1], 6'h00});
      wr(16'hff2b, 8'h59 + 8'(i[0]));
      wr(16'hff28, 8'hb1); // reference still on
      wait_irq(2, n);
      check(16'(n),
            (i[0] == i[1]) ? 16'h0062 : 16'h0000);
      chk_res(0);
    end
    // reset in mid-conversion brings the threshold back to zero
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd(16'hff2b);
    check(rd_val, 16'h0000);
    wr(16'hff28, 8'h00);
    print_verdict();
  end
endmodule

`default_nettype wire
